//--- src/sample_stage_consts.vh
`ifndef SAMPLE_STAGE_CONSTS_VH
`define SAMPLE_STAGE_CONSTS_VH

// Register byte offsets on the APB slave.
`define OFS_CONTROL        12'h000
`define OFS_DENSITY_TARGET 12'h004
`define OFS_HOST_GAIN      12'h008
`define OFS_DIVIDER        12'h00C
`define OFS_STATUS         12'h010

// Control register field positions.
`define CTL_FMT_LSB        0
`define CTL_WIDTH_LSB      2
`define CTL_QEN_BIT        5
`define CTL_AGC_AUTO_BIT   6
`define CTL_FRAC_EN_BIT    7
`define CTL_SRC_SEL_BIT    8
`define CTL_EXT_SEL_BIT    9
`define CTL_REF_DIV4_BIT   10
`define CTL_WIDTH_BITS     11

// Divider register field positions.
`define DIV_LOW_LSB        0
`define DIV_MOD_LSB        16

// Status register field positions.
`define STS_GAIN_LSB       0
`define STS_COUNT_LSB      8

// Reset values.
`define CONTROL_RESET      11'h069
`define TARGET_RESET       10'h0AA
`define HOST_GAIN_RESET    6'h20
`define LOW_RESET          12'h001
`define MOD_RESET          12'hFFF
`define GAIN_RESET         6'h20

// Output coding and width codes.
`define FMT_UNSIGNED       2'h0
`define FMT_SIGN_MAG       2'h1
`define WIDTH_1BIT         3'h0
`define WIDTH_2BIT         3'h2
`define WIDTH_3BIT         3'h4

// Gain loop window and divider modulus.
`define WINDOW_LEN         10'h200
`define WINDOW_LAST        9'h1FF
`define DIV_SPAN           13'h1000
`define GAIN_MAX           6'h3F
`define GAIN_MIN           6'h00

// Sample clock ceiling and system clock rate, in Hz.
`define SAMPLE_CLK_MAX_HZ  44000000
`define MCLK_HZ            10000000

`endif

//--- src/sample_stage.v
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "sample_stage_consts.vh"

// Behaviour
// - Count samples with magnitude bit set over 512 sample ticks, compare to target.
// - Target is an integer count; density equals target divided by 512.
// - Format 00 unsigned, 01 sign-magnitude, 1x two's complement.
// - Reset leaves two-bit sign-magnitude output.
// - Width 1 or 2 bits with I and Q, up to 3 bits with I only.
// - Quadrature enable 0 gives I only, 1 gives I and Q.
// - One and two bit modes: MSB on upper pin, LSB on lower pin.
// - Three-bit mode: MSB on I upper, middle on I lower, LSB on Q upper.
// - Width field 000 one bit, 010 two bits, 100 three bits.
// - Sign-magnitude: sign first, 1 negative; magnitudes per level table.
// - Two's complement and unsigned two-bit codes follow the level table.
// - Sample clock never exceeds 44 MHz on any path.
// - Fractional ratio equals low over (4096 minus modulus plus low).
// - Fractional divider alternates adjacent integer division periods.
// - Path enable routes the sample clock through or around the fractional divider.
// - Source select takes the clock before or after the reference divider.
// - Path enable and source select combine as in the clock selection table.
// - External select 1 clocks sampling from the external sample clock input.
// - Alignment: source drives its sample clock out, all devices use external clock.
// - Gain mode selects loop-driven gain or host-programmed gain value.
module sample_stage (
  input  wire        mclk,
  input  wire        reset,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [2:0]  i_level,
  input  wire [2:0]  q_level,
  input  wire        external_sample_clock_input,
  output reg         in_phase_upper_pin,
  output reg         in_phase_lower_pin,
  output reg         quadrature_upper_pin,
  output reg         quadrature_lower_pin,
  output reg         baseband_clock_output,
  output reg         sample_strobe,
  output reg  [5:0]  pga_gain
);

  // The sample rate is derived from mclk, so it can never exceed mclk itself.
  localparam SAMPLE_CLK_OK = (`MCLK_HZ <= `SAMPLE_CLK_MAX_HZ);

  reg  [10:0] control_q;
  reg  [9:0]  density_target_q;
  reg  [5:0]  host_gain_q;
  reg  [11:0] divider_low_count_q;
  reg  [11:0] divider_modulus_count_q;
  reg  [5:0]  loop_gain_q;
  reg  [9:0]  mag_count_q;
  reg  [8:0]  window_pos_q;
  reg  [9:0]  last_count_q;
  reg  [1:0]  ref_div_q;
  reg  [12:0] frac_acc_q;
  reg         ext_clk_q;
  reg         ext_clk_prev_q;

  wire [1:0] format_select                = control_q[`CTL_FMT_LSB +: 2];
  wire [2:0] width_select                 = control_q[`CTL_WIDTH_LSB +: 3];
  wire       quadrature_channel_enable    = control_q[`CTL_QEN_BIT];
  wire       gain_control_mode            = control_q[`CTL_AGC_AUTO_BIT];
  wire       fractional_clock_path_enable = control_q[`CTL_FRAC_EN_BIT];
  wire       sample_clock_source_select   = control_q[`CTL_SRC_SEL_BIT];
  wire       external_sample_clock_select = control_q[`CTL_EXT_SEL_BIT];
  wire       ref_div_by_four              = control_q[`CTL_REF_DIV4_BIT];

  // Map a quantiser index (0 is level -7, 7 is level +7) to a 3-bit code.
  function [2:0] encode_level;
    input [2:0] idx;
    input [1:0] fmt;
    begin
      if (fmt == `FMT_UNSIGNED) begin
        encode_level = idx;
      end else if (fmt == `FMT_SIGN_MAG) begin
        encode_level = idx[2] ? {1'b0, idx[1:0]} : {1'b1, ~idx[1:0]};
      end else begin
        encode_level = {~idx[2], idx[1:0]};
      end
    end
  endfunction

  // Magnitude bit of the two-bit sign-magnitude code: set for levels -7, -5, +5 and +7.
  function mag_bit;
    input [2:0] idx;
    begin
      mag_bit = idx[2] ? idx[1] : ~idx[1];
    end
  endfunction

  wire [2:0] i_code = encode_level(i_level, format_select);
  wire [2:0] q_code = encode_level(q_level, format_select);

  // Reference stage: raw reference is every mclk, divided reference every 2 or 4.
  wire ref_div_tick = ref_div_by_four ? (ref_div_q == 2'h3) : ref_div_q[0];
  wire src_tick     = sample_clock_source_select ? 1'b1 : ref_div_tick;

  // Fractional divider: accumulate low count, emit when modulus span is crossed.
  wire [12:0] frac_span = `DIV_SPAN - {1'b0, divider_modulus_count_q}
                          + {1'b0, divider_low_count_q};
  wire [12:0] frac_sum  = frac_acc_q + {1'b0, divider_low_count_q};
  wire        frac_hit  = src_tick && (frac_sum >= frac_span);

  wire int_tick  = fractional_clock_path_enable ? frac_hit : src_tick;
  wire ext_tick  = ext_clk_q && !ext_clk_prev_q;
  wire samp_tick = external_sample_clock_select ? ext_tick : int_tick;

  always @(posedge mclk) begin
    if (reset) begin
      ref_div_q      <= 2'h0;
      frac_acc_q     <= 13'h0000;
      ext_clk_q      <= 1'b0;
      ext_clk_prev_q <= 1'b0;
    end else begin
      ref_div_q      <= ref_div_q + 2'h1;
      ext_clk_q      <= external_sample_clock_input;
      ext_clk_prev_q <= ext_clk_q;
      if (src_tick && fractional_clock_path_enable) begin
        // Residue carries over, so periods alternate between adjacent integers.
        frac_acc_q <= frac_hit ? (frac_sum - frac_span) : frac_sum;
      end
    end
  end

  // Data pins and baseband clock update only on sample ticks; sample_strobe follows samp_tick every cycle.
  always @(posedge mclk) begin
    if (reset) begin
      in_phase_upper_pin    <= 1'b0;
      in_phase_lower_pin    <= 1'b0;
      quadrature_upper_pin  <= 1'b0;
      quadrature_lower_pin  <= 1'b0;
      baseband_clock_output <= 1'b0;
      sample_strobe         <= 1'b0;
    end else begin
      sample_strobe <= samp_tick;
      if (samp_tick) begin
        baseband_clock_output <= ~baseband_clock_output;
        in_phase_upper_pin    <= i_code[2];
        if (width_select == `WIDTH_3BIT) begin
          // The I code supplies the LSB on the Q upper pin; quadrature enable is not used here.
          in_phase_lower_pin   <= i_code[1];
          quadrature_upper_pin <= i_code[0];
          quadrature_lower_pin <= 1'b0;
        end else if (width_select == `WIDTH_2BIT) begin
          in_phase_lower_pin   <= i_code[1];
          quadrature_upper_pin <= quadrature_channel_enable & q_code[2];
          quadrature_lower_pin <= quadrature_channel_enable & q_code[1];
        end else begin
          in_phase_lower_pin   <= 1'b0;
          quadrature_upper_pin <= quadrature_channel_enable & q_code[2];
          quadrature_lower_pin <= 1'b0;
        end
      end
    end
  end

  // Gain loop.
  wire [9:0] count_with_this = mag_count_q + {9'h000, mag_bit(i_level)};

  always @(posedge mclk) begin
    if (reset) begin
      mag_count_q  <= 10'h000;
      window_pos_q <= 9'h000;
      last_count_q <= 10'h000;
      loop_gain_q  <= `GAIN_RESET;
      pga_gain     <= `GAIN_RESET;
    end else begin
      pga_gain <= gain_control_mode ? loop_gain_q : host_gain_q;
      if (samp_tick) begin
        window_pos_q <= window_pos_q + 9'h001;
        if (window_pos_q == `WINDOW_LAST) begin
          mag_count_q  <= 10'h000;
          last_count_q <= count_with_this;
          if (gain_control_mode) begin
            if (count_with_this > density_target_q && loop_gain_q != `GAIN_MIN) begin
              loop_gain_q <= loop_gain_q - 6'h01;
            end else if (count_with_this < density_target_q
                         && loop_gain_q != `GAIN_MAX) begin
              loop_gain_q <= loop_gain_q + 6'h01;
            end
          end
        end else begin
          mag_count_q <= count_with_this;
        end
      end
    end
  end

  // APB slave: one wait state, write and read data at the edge with pready high.
  wire apb_access = psel && penable && !pready;
  wire apb_commit = psel && penable && pready;

  always @(posedge mclk) begin
    if (reset) begin
      pready                  <= 1'b0;
      pslverr                 <= 1'b0;
      prdata                  <= 32'h00000000;
      control_q               <= `CONTROL_RESET;
      density_target_q        <= `TARGET_RESET;
      host_gain_q             <= `HOST_GAIN_RESET;
      divider_low_count_q     <= `LOW_RESET;
      divider_modulus_count_q <= `MOD_RESET;
    end else begin
      pready <= apb_access;
      if (apb_access) begin
        pslverr <= 1'b0;
        prdata  <= 32'h00000000;
        if (paddr == `OFS_CONTROL) begin
          prdata[10:0] <= control_q;
        end else if (paddr == `OFS_DENSITY_TARGET) begin
          prdata[9:0] <= density_target_q;
        end else if (paddr == `OFS_HOST_GAIN) begin
          prdata[5:0] <= host_gain_q;
        end else if (paddr == `OFS_DIVIDER) begin
          prdata[`DIV_LOW_LSB +: 12] <= divider_low_count_q;
          prdata[`DIV_MOD_LSB +: 12] <= divider_modulus_count_q;
        end else if (paddr == `OFS_STATUS) begin
          prdata[`STS_GAIN_LSB +: 6]   <= pga_gain;
          prdata[`STS_COUNT_LSB +: 10] <= last_count_q;
        end else begin
          pslverr <= 1'b1;
        end
      end else if (apb_commit) begin
        pslverr <= 1'b0;
        if (pwrite) begin
          if (paddr == `OFS_CONTROL) begin
            control_q <= pwdata[10:0];
          end else if (paddr == `OFS_DENSITY_TARGET) begin
            density_target_q <= pwdata[9:0];
          end else if (paddr == `OFS_HOST_GAIN) begin
            host_gain_q <= pwdata[5:0];
          end else if (paddr == `OFS_DIVIDER) begin
            // Ratios above one half are the host's to avoid.
            divider_low_count_q     <= pwdata[`DIV_LOW_LSB +: 12];
            divider_modulus_count_q <= pwdata[`DIV_MOD_LSB +: 12];
          end
        end
      end
    end
  end

endmodule // sample_stage

//--- sim/sample_stage_checker.sv
`timescale 1ns/1ps
module sample_stage_checker (
  input wire        mclk,
  input wire        reset,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        in_phase_upper_pin,
  input wire        in_phase_lower_pin,
  input wire        quadrature_upper_pin,
  input wire        quadrature_lower_pin,
  input wire        baseband_clock_output,
  input wire        sample_strobe,
  input wire [5:0]  pga_gain
);
  wire [4:0] pins = {in_phase_upper_pin, in_phase_lower_pin, quadrature_upper_pin,
                     quadrature_lower_pin, baseband_clock_output};
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  apb_answer_a: assert property (psel && $rose(penable) |=> pready && penable)
    else $error("pready late");
  ready_pulse_a: assert property (pready |=> !pready) else $error("pready too long");
  ready_access_a: assert property (pready |-> psel && penable) else $error("stray pready");
  map_error_a: assert property (pready && paddr > 12'h010 |-> pslverr) else $error("no pslverr");
  error_data_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused data");
  pins_hold_a: assert property (!sample_strobe |-> $stable(pins))
    else $error("pins moved");
  clock_toggle_a: assert property (sample_strobe |-> pins[0] != $past(pins[0]))
    else $error("clock out idle");
  gain_reset_a: assert property ($fell(reset) |-> pga_gain == 6'h20 && !sample_strobe)
    else $error("reset values");
  cover property (pslverr);
  cover property (sample_strobe && in_phase_upper_pin);
  cover property ($changed(pga_gain));
endmodule // sample_stage_checker

bind sample_stage sample_stage_checker sample_stage_checker_i (
  .mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .in_phase_upper_pin(in_phase_upper_pin), .in_phase_lower_pin(in_phase_lower_pin),
  .quadrature_upper_pin(quadrature_upper_pin), .quadrature_lower_pin(quadrature_lower_pin),
  .baseband_clock_output(baseband_clock_output), .sample_strobe(sample_strobe),
  .pga_gain(pga_gain));

//--- sim/baseband_rx.sv
`timescale 1ns/1ps
module baseband_rx (
  input  wire logic   mclk,
  input  wire logic   reset,
  input  wire logic   i_upper,
  input  wire logic   i_lower,
  input  wire logic   q_upper,
  input  wire logic   q_lower,
  input  wire logic   strobe,
  output logic [3:0]  word,
  output int unsigned count
);
  // Pins are taken only on the strobe, as they are promised to stand between ticks.
  always @(posedge mclk) begin
    if (reset) begin
      word  <= 4'h0;
      count <= 0;
    end else if (strobe) begin
      word  <= {i_upper, i_lower, q_upper, q_lower};
      count <= count + 1;
    end
  end
endmodule // baseband_rx

//--- sim/testbench.sv
`timescale 1ns/1ps
`include "sample_stage_consts.vh"
module testbench;
  logic        mclk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        ext_clk = 1'b0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rdat;
  logic [2:0]  i_level = 3'h3, q_level = 3'h0, c, qc;
  logic [3:0]  e;
  wire  [31:0] prdata;
  wire         pready, pslverr, iu, il, qu, ql, bbclk, strobe;
  wire  [5:0]  pga_gain;
  wire  [3:0]  word;
  int unsigned count;
  int          num_errors = 0, total_checks = 0, cyc = 0, n0, d;
  int          rate [6] = '{420, 210, 840, 120, 60, 240};
  logic [11:0] ctl [6] = '{12'h029, 12'h429, 12'h129, 12'h0A9, 12'h4A9, 12'h1A9};
  always #50 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      num_errors = num_errors + 1;
      close_out;
    end
  end
  sample_stage sample_stage_i (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .i_level(i_level), .q_level(q_level),
    .external_sample_clock_input(ext_clk), .in_phase_upper_pin(iu), .in_phase_lower_pin(il),
    .quadrature_upper_pin(qu), .quadrature_lower_pin(ql), .baseband_clock_output(bbclk),
    .sample_strobe(strobe), .pga_gain(pga_gain));
  baseband_rx baseband_rx_i (.mclk(mclk), .reset(reset), .i_upper(iu), .i_lower(il),
    .q_upper(qu), .q_lower(ql), .strobe(strobe), .word(word), .count(count));
  task close_out;
    $display("errors %0d checks %0d", num_errors, total_checks);
    if (num_errors == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    total_checks++;
    if (g !== x) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, x, g);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] dat);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dat;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input string nm, input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(nm, x, rdat);
  endtask
  task wait_ticks(input int n);
    while (count < n) @(posedge mclk);
    repeat (4) @(posedge mclk);
  endtask
  // Each external edge must end in a strobe; the low phase keeps it under half of mclk.
  task tick;
    n0 = count;
    ext_clk <= 1'b1;
    while (count == n0) @(posedge mclk);
    ext_clk <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask
  function logic [2:0] code(input logic [1:0] f, input logic [2:0] x);
    if (f == 2'h0) code = x;
    else if (f == 2'h1) code = {~x[2], x[2] ? x[1:0] : ~x[1:0]};
    else code = {~x[2], x[1:0]};
  endfunction
  initial begin
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    rd("control", `OFS_CONTROL, {21'h0, 11'h069});
    rd("target", `OFS_DENSITY_TARGET, 32'h0AA);
    rd("host gain", `OFS_HOST_GAIN, 32'h20);
    rd("divider", `OFS_DIVIDER, 32'h0FFF0001);
    rd("unmapped", 12'h014, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    wait_ticks(8);
    chk("default pins", 32'h2, {30'h0, word[3:2]});
    i_level <= 3'h7;
    wait_ticks(1536);
    rd("status lower", `OFS_STATUS, 32'h0002001D);
    i_level <= 3'h4;
    wait_ticks(2560);
    rd("status raise", `OFS_STATUS, 32'h0000001F);
    wr_reg(`OFS_DENSITY_TARGET, 32'h0);
    wait_ticks(3584);
    rd("status hold", `OFS_STATUS, 32'h0000001F);
    wr_reg(`OFS_HOST_GAIN, 32'h05);
    wr_reg(`OFS_CONTROL, 32'h029);
    repeat (3) @(posedge mclk);
    chk("pga gain", 32'h05, {26'h0, pga_gain});
    wr_reg(`OFS_DIVIDER, 32'h0FFB0002);
    for (int k = 0; k < 6; k++) begin
      wr_reg(`OFS_CONTROL, {20'h0, ctl[k]});
      repeat (8) @(posedge mclk);
      n0 = count;
      repeat (840) @(posedge mclk);
      d = count - n0 - rate[k];
      chk("tick rate", 32'h0, {31'h0, d > 1 || d < -1});
    end
    for (int f = 0; f < 4; f++)
      for (int w = 0; w < 5; w += 2)
        for (int q = 0; q < 2; q++) begin
          if (w == 4 && q == 0) continue;
          wr_reg(`OFS_CONTROL, f | w << 2 | q << 5 | 32'h200);
          for (int x = 0; x < 8; x++) begin
            i_level <= x[2:0];
            q_level <= ~x[2:0];
            tick;
            c = code(f[1:0], x[2:0]);
            qc = code(f[1:0], ~x[2:0]);
            if (w == 4) e = {c, 1'b0};
            else if (w == 2) e = {c[2:1], q ? qc[2:1] : 2'b00};
            else e = {c[2], 1'b0, q ? qc[2] : 1'b0, 1'b0};
            chk("pins", {28'h0, e}, {28'h0, word});
          end
        end
    close_out;
  end
  task wr_reg(input logic [11:0] a, input logic [31:0] dat);
    apb(1'b1, a, dat);
  endtask
endmodule // testbench
